// ### lcso_pkg.sv
// constants shared by the link configuration status output block
package lcso_pkg;
    localparam int LTSSM_W      = 6;
    localparam int NUM_PF       = 2;
    localparam int OBFF_W       = 2;
    localparam int DPA_STATE_W  = 5;
    localparam logic [5:0] LTSSM_DETECT_QUIET = 6'h00;
    localparam logic [5:0] LTSSM_L0           = 6'h10;
    localparam logic [5:0] LTSSM_HOT_RESET    = 6'h27;
    localparam logic [1:0] OBFF_DISABLED      = 2'h0;
    localparam logic [1:0] OBFF_MSG_A         = 2'h1;
    localparam logic [1:0] OBFF_MSG_B         = 2'h2;
    localparam logic [1:0] OBFF_WAKE          = 2'h3;
    localparam logic       RCB_64             = 1'b0;
    localparam logic       RCB_128            = 1'b1;
    localparam int RP_RCB_BIT   = 0;
endpackage

// ### lcso_link_event.sv
// sticky link event status bits and root-port link event notification
`timescale 1ns/1ns
`default_nettype none
module lcso_link_event
(
    // clock and reset
    input  wire logic CLK_SYS_I,
    input  wire logic SYS_RST_I,
    // mode
    input  wire logic root_port_i,
    // event pulses
    input  wire logic bw_mgmt_evt_i,
    input  wire logic auto_bw_evt_i,
    input  wire logic eq_req_evt_i,
    // interrupt enables
    input  wire logic bw_mgmt_ie_i,
    input  wire logic auto_bw_ie_i,
    input  wire logic eq_ie_i,
    // status clears (software write-one-to-clear)
    input  wire logic bw_mgmt_clr_i,
    input  wire logic auto_bw_clr_i,
    input  wire logic eq_req_clr_i,
    // results
    output logic      bw_mgmt_sts_o,
    output logic      auto_bw_sts_o,
    output logic      eq_req_sts_o,
    output logic      notify_o
);
    logic bw_reg;
    logic auto_reg;
    logic eq_reg;
    logic notify_reg;
    logic bw_next;
    logic auto_next;
    logic eq_next;
    logic notify_next;

    // set wins over a clear in the same cycle
    assign bw_next     = bw_mgmt_evt_i | (bw_reg & ~bw_mgmt_clr_i);      // R9
    assign auto_next   = auto_bw_evt_i | (auto_reg & ~auto_bw_clr_i);    // R10
    assign eq_next     = eq_req_evt_i | (eq_reg & ~eq_req_clr_i);        // R11
    // endpoint never notifies
    assign notify_next = root_port_i & ((bw_mgmt_evt_i & bw_mgmt_ie_i)
                       | (auto_bw_evt_i & auto_bw_ie_i)
                       | (eq_req_evt_i & eq_ie_i));                      // R12

    always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I)
    begin
        if (SYS_RST_I)
        begin
            bw_reg     <= 1'b0;
            auto_reg   <= 1'b0;
            eq_reg     <= 1'b0;
            notify_reg <= 1'b0;
        end
        else
        begin
            bw_reg     <= bw_next;
            auto_reg   <= auto_next;
            eq_reg     <= eq_next;
            notify_reg <= notify_next;
        end
    end

    assign bw_mgmt_sts_o = bw_reg;
    assign auto_bw_sts_o = auto_reg;
    assign eq_req_sts_o  = eq_reg;
    assign notify_o      = notify_reg;
endmodule
`default_nettype wire

// ### lcso_status_out.sv
// registered configuration status outputs toward the user logic
`timescale 1ns/1ns
`default_nettype none
// What this block does
// R1: Drive 6-bit training state code, e.g. 00 detect quiet, 10 L0, 27 hot reset.
// R2: Completion boundary status bit: 0 means 64 bytes, 1 means 128 bytes.
// R3: Endpoint: completion boundary bit n reports physical function n.
// R4: Root mode: bit 0 reports root port setting, bit 1 reserved.
// R5: Endpoint: one-cycle pulse when config write changes power allocation state.
// R6: Each power allocation notify bit belongs to one function; bit 0 is function 0.
// R7: Power allocation notify stays inactive in root port mode.
// R8: Buffer flush/fill enable field presented as 00/01/10/11 encodings.
// R9: Root port: notify on local bandwidth change when its interrupt enable set.
// R10: Root port: notify on autonomous bandwidth change when its enable set.
// R11: Equalization request sets status; root port notifies when its enable set.
// R12: Link event notification never asserted as an endpoint.
// R13: All outputs registered on user clock; levels follow fields continuously.
module lcso_status_out
#(
    parameter int NUM_PF      = lcso_pkg::NUM_PF,
    parameter int DPA_STATE_W = lcso_pkg::DPA_STATE_W
)
(
    // clock and reset
    input  wire logic                    CLK_SYS_I,
    input  wire logic                    SYS_RST_I,
    // configuration
    input  wire logic                    ROOT_PORT_I,
    input  wire logic [5:0]              LTSSM_STATE_I,
    input  wire logic [NUM_PF-1:0]       RCB_SETTING_I,
    input  wire logic [1:0]              OBFF_FIELD_I,
    // power allocation control writes, per function
    input  wire logic [NUM_PF-1:0]       DPA_WR_I,
    input  wire logic [DPA_STATE_W-1:0]  DPA_WR_DATA_I,
    // link events and enables
    input  wire logic                    BW_MGMT_EVT_I,
    input  wire logic                    AUTO_BW_EVT_I,
    input  wire logic                    EQ_REQ_EVT_I,
    input  wire logic                    BW_MGMT_IE_I,
    input  wire logic                    AUTO_BW_IE_I,
    input  wire logic                    EQ_IE_I,
    input  wire logic                    BW_MGMT_CLR_I,
    input  wire logic                    AUTO_BW_CLR_I,
    input  wire logic                    EQ_REQ_CLR_I,
    // status outputs
    output logic [5:0]                   LTSSM_STATE_O,
    output logic [NUM_PF-1:0]            RCB_STATUS_O,
    output logic [NUM_PF-1:0]            DPA_SUBSTATE_CHANGE_O,
    output logic [1:0]                   OBFF_ENABLE_O,
    output logic                         BW_MGMT_STS_O,
    output logic                         AUTO_BW_STS_O,
    output logic                         EQ_REQ_STS_O,
    output logic                         LINK_EVENT_NOTIFY_O
);
    // all-clear values used in reset
    localparam logic [NUM_PF-1:0]      PF_NONE       = '0;
    localparam logic [DPA_STATE_W-1:0] DPA_STATE_RST = '0;

    // level copies
    logic [5:0]             ltssm_reg;
    logic [5:0]             ltssm_next;
    logic [1:0]             obff_reg;
    logic [1:0]             obff_next;

    // completion boundary status
    logic [NUM_PF-1:0]      rcb_reg;
    logic [NUM_PF-1:0]      rcb_next;

    // power allocation notification
    logic [NUM_PF-1:0]      dpa_pulse_reg;
    logic [NUM_PF-1:0]      dpa_pulse_next;
    logic [DPA_STATE_W-1:0] dpa_state_reg [NUM_PF];
    logic                   endpoint_mode;

    // one live bit in root mode, every bit live as an endpoint
    function automatic logic rcb_bit_valid
    (
        input logic root_mode,
        input int   idx
    );
        rcb_bit_valid = !root_mode || (idx == lcso_pkg::RP_RCB_BIT);
    endfunction

    // a write is an event only if the stored substate moves;
    // rewriting the same substate must stay silent
    function automatic logic dpa_write_changes
    (
        input logic                   wr,
        input logic [DPA_STATE_W-1:0] new_state,
        input logic [DPA_STATE_W-1:0] old_state
    );
        dpa_write_changes = wr && (new_state != old_state);
    endfunction

    // mode is a strap, assumed stable while traffic runs
    assign endpoint_mode = ~ROOT_PORT_I;
    assign ltssm_next    = LTSSM_STATE_I;   // R1
    assign obff_next     = OBFF_FIELD_I;    // R8

    // root mode: reserved boundary bits read as 64 bytes
    genvar g;
    generate
        for (g = 0; g < NUM_PF; g++)
        begin : g_rcb
            assign rcb_next[g] = rcb_bit_valid(ROOT_PORT_I, g)
                               ? RCB_SETTING_I[g] : lcso_pkg::RCB_64;   // R2 R3 R4
        end
        // root port never pulses, though the stored substate still tracks writes
        for (g = 0; g < NUM_PF; g++)
        begin : g_dpa
            assign dpa_pulse_next[g] = endpoint_mode
                                     & dpa_write_changes(DPA_WR_I[g], DPA_WR_DATA_I,
                                                         dpa_state_reg[g]);   // R5 R6 R7

            // updated in both modes so a later endpoint write compares correctly
            always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I)
            begin
                if (SYS_RST_I)
                begin
                    dpa_state_reg[g] <= DPA_STATE_RST;
                end
                else if (DPA_WR_I[g])
                begin
                    dpa_state_reg[g] <= DPA_WR_DATA_I;
                end
            end
        end
    endgenerate

    // reset code is detect quiet, so user logic sees no link yet
    always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I)
    begin
        if (SYS_RST_I)
        begin
            ltssm_reg <= lcso_pkg::LTSSM_DETECT_QUIET;
        end
        else
        begin
            ltssm_reg <= ltssm_next;   // R1 R13
        end
    end

    // reserved bit held low in root mode
    always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I)
    begin
        if (SYS_RST_I)
        begin
            rcb_reg <= PF_NONE;
        end
        else
        begin
            rcb_reg <= rcb_next;   // R2
        end
    end

    // pulses last exactly one cycle
    always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I)
    begin
        if (SYS_RST_I)
        begin
            dpa_pulse_reg <= PF_NONE;
        end
        else
        begin
            dpa_pulse_reg <= dpa_pulse_next;   // R5
        end
    end

    // field passes unchanged; user logic picks the signalling
    always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I)
    begin
        if (SYS_RST_I)
        begin
            obff_reg <= lcso_pkg::OBFF_DISABLED;
        end
        else
        begin
            obff_reg <= obff_next;   // R8 R13
        end
    end

    // status bits set in both modes so software can poll them
    lcso_link_event u_link_event
    (
        // clock and reset
        .CLK_SYS_I     (CLK_SYS_I),
        .SYS_RST_I     (SYS_RST_I),

        // mode
        .root_port_i   (ROOT_PORT_I),

        // event pulses
        .bw_mgmt_evt_i (BW_MGMT_EVT_I),
        .auto_bw_evt_i (AUTO_BW_EVT_I),
        .eq_req_evt_i  (EQ_REQ_EVT_I),

        // interrupt enables
        .bw_mgmt_ie_i  (BW_MGMT_IE_I),
        .auto_bw_ie_i  (AUTO_BW_IE_I),
        .eq_ie_i       (EQ_IE_I),

        // status clears
        .bw_mgmt_clr_i (BW_MGMT_CLR_I),
        .auto_bw_clr_i (AUTO_BW_CLR_I),
        .eq_req_clr_i  (EQ_REQ_CLR_I),

        // results
        .bw_mgmt_sts_o (BW_MGMT_STS_O),
        .auto_bw_sts_o (AUTO_BW_STS_O),
        .eq_req_sts_o  (EQ_REQ_STS_O),
        .notify_o      (LINK_EVENT_NOTIFY_O)
    );

    // every output is a flop, so user logic needs no retiming stage
    assign LTSSM_STATE_O         = ltssm_reg;
    assign RCB_STATUS_O          = rcb_reg;
    assign DPA_SUBSTATE_CHANGE_O = dpa_pulse_reg;
    assign OBFF_ENABLE_O         = obff_reg;
endmodule
`default_nettype wire

// ### lcso_status_out_asserts.sv
// port-level checks for the status output block
`timescale 1ns/1ns
`default_nettype none
module lcso_status_out_asserts
#(
    parameter int NUM_PF      = 2,
    parameter int DPA_STATE_W = 5
)
(
    // clock, reset, mode
    input wire logic              CLK_SYS_I, SYS_RST_I, ROOT_PORT_I,
    // configuration inputs
    input wire logic [5:0]        LTSSM_STATE_I,
    input wire logic [NUM_PF-1:0] RCB_SETTING_I, DPA_WR_I,
    input wire logic [1:0]        OBFF_FIELD_I,
    // events, enables, clears
    input wire logic              BW_MGMT_EVT_I, AUTO_BW_EVT_I, EQ_REQ_EVT_I,
    input wire logic              BW_MGMT_IE_I, AUTO_BW_IE_I, EQ_IE_I, AUTO_BW_CLR_I,
    // outputs watched
    input wire logic [5:0]        LTSSM_STATE_O,
    input wire logic [NUM_PF-1:0] RCB_STATUS_O, DPA_SUBSTATE_CHANGE_O,
    input wire logic [1:0]        OBFF_ENABLE_O,
    input wire logic              BW_MGMT_STS_O, AUTO_BW_STS_O, EQ_REQ_STS_O,
    input wire logic              LINK_EVENT_NOTIFY_O
);
    default clocking cb @(posedge CLK_SYS_I); endclocking
    default disable iff (SYS_RST_I);
    ltssm_follow_a: assert property (1'b1 |=> LTSSM_STATE_O == $past(LTSSM_STATE_I))
        else $error("training state not copied");
    obff_follow_a: assert property (1'b1 |=> OBFF_ENABLE_O == $past(OBFF_FIELD_I))
        else $error("buffer flush field not copied");
    rcb_map_a: assert property (1'b1 |=> RCB_STATUS_O == ($past(RCB_SETTING_I)
        & {{(NUM_PF-1){!$past(ROOT_PORT_I)}}, 1'b1})) else $error("boundary status wrong");
    dpa_root_quiet_a: assert property (ROOT_PORT_I |=> DPA_SUBSTATE_CHANGE_O == '0)
        else $error("power allocation pulse in root mode");
    dpa_cause_a: assert property (DPA_SUBSTATE_CHANGE_O != '0 |->
        ($past(DPA_WR_I) & DPA_SUBSTATE_CHANGE_O) == DPA_SUBSTATE_CHANGE_O)
        else $error("power allocation pulse without write");
    notify_ep_quiet_a: assert property (!ROOT_PORT_I |=> !LINK_EVENT_NOTIFY_O)
        else $error("link event as endpoint");
    notify_cause_a: assert property (!(BW_MGMT_EVT_I && BW_MGMT_IE_I || AUTO_BW_EVT_I
        && AUTO_BW_IE_I || EQ_REQ_EVT_I && EQ_IE_I) |=> !LINK_EVENT_NOTIFY_O)
        else $error("link event without enabled cause");
    bw_notify_a: assert property (ROOT_PORT_I && BW_MGMT_EVT_I && BW_MGMT_IE_I
        |=> LINK_EVENT_NOTIFY_O && BW_MGMT_STS_O) else $error("bandwidth event missed");
    eq_notify_a: assert property (ROOT_PORT_I && EQ_REQ_EVT_I && EQ_IE_I
        |=> LINK_EVENT_NOTIFY_O && EQ_REQ_STS_O) else $error("equalization event missed");
    auto_sticky_a: assert property (AUTO_BW_EVT_I ##1 !AUTO_BW_CLR_I |=> AUTO_BW_STS_O)
        else $error("autonomous status lost");
endmodule
bind lcso_status_out lcso_status_out_asserts #(.NUM_PF(NUM_PF), .DPA_STATE_W(DPA_STATE_W))
    lcso_status_out_asserts_i (.*);
`default_nettype wire

// ### lcso_user_model.sv
// user-side logic that counts cycles carrying any event pulse from the block
`timescale 1ns/1ns
`default_nettype none
module lcso_user_model
(
    // clock, reset, pulses seen
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       notify_i,
    input  wire logic [1:0] dpa_i,
    // count of cycles holding any pulse
    output logic      [7:0] events_o
);
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i) events_o <= 8'h00;
        else if (notify_i || dpa_i != 2'b00) events_o <= events_o + 8'h01;
    end
endmodule
`default_nettype wire

// ### tb_top.sv
// self-checking bench for the status output block
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    logic       clk = 0, rst = 1, rp = 0, nfy;
    logic [5:0] lt = 6'h10, lto;
    logic [1:0] rcb = 2'h3, ob = 2'h3, dw = 0, rcbo, dpo, obo;
    logic [4:0] dd = 0;
    logic [2:0] ev = 0, ie = 0, clr = 0, sts;
    logic [7:0] cnt;
    int errors = 0, tests_run = 0;
    // rows: mode, state, boundary, flush field, expected boundary status
    logic [12:0] rows [4] = '{{1'b0, 6'h00, 2'h2, 2'h0, 2'h2}, {1'b1, 6'h10, 2'h3, 2'h1, 2'h1},
                              {1'b0, 6'h27, 2'h1, 2'h2, 2'h1}, {1'b1, 6'h1A, 2'h2, 2'h3, 2'h0}};
    lcso_status_out lcso_status_out_i (.CLK_SYS_I(clk), .SYS_RST_I(rst), .ROOT_PORT_I(rp),
        .LTSSM_STATE_I(lt), .RCB_SETTING_I(rcb), .OBFF_FIELD_I(ob), .DPA_WR_I(dw),
        .DPA_WR_DATA_I(dd), .BW_MGMT_EVT_I(ev[2]), .AUTO_BW_EVT_I(ev[1]), .EQ_REQ_EVT_I(ev[0]),
        .BW_MGMT_IE_I(ie[2]), .AUTO_BW_IE_I(ie[1]), .EQ_IE_I(ie[0]), .BW_MGMT_CLR_I(clr[2]),
        .AUTO_BW_CLR_I(clr[1]), .EQ_REQ_CLR_I(clr[0]), .LTSSM_STATE_O(lto), .RCB_STATUS_O(rcbo),
        .DPA_SUBSTATE_CHANGE_O(dpo), .OBFF_ENABLE_O(obo), .BW_MGMT_STS_O(sts[2]),
        .AUTO_BW_STS_O(sts[1]), .EQ_REQ_STS_O(sts[0]), .LINK_EVENT_NOTIFY_O(nfy));
    lcso_user_model lcso_user_model_i (.clk_i(clk), .rst_i(rst), .notify_i(nfy), .dpa_i(dpo),
        .events_o(cnt));
    initial forever #50 clk = ~clk;
    task chk(input string n, input logic [7:0] s, input logic [7:0] e);
        tests_run++;
        if (s !== e)
        begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", n, e, s);
        end
    endtask
    task dpa(input logic [1:0] w, input logic [4:0] d, input logic [1:0] e);
        dw = w; dd = d;
        @(negedge clk); dw = 0;
        chk("dpa_pulse", dpo, e);
        @(negedge clk); chk("dpa_end", dpo, 0);
    endtask
    task lev(input logic [2:0] e, input logic [2:0] en, input logic n);
        ev = e; ie = en;
        @(negedge clk); ev = 0; clr = 3'h7;
        chk("notify", nfy, n);
        chk("status", sts, e);
        @(negedge clk); clr = 0;
        chk("notify_end", nfy, 0); chk("cleared", sts, 0);
    endtask
    task give_verdict;
        $display("checks %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial
    begin
        repeat (5) @(negedge clk);
        chk("reset_state", {lto, rcbo}, 0); chk("reset_flush", {sts, nfy, obo}, 0);
        rst = 0;
        $display("test reset done");
        foreach (rows[i])
        begin
            {rp, lt, rcb, ob} = rows[i][12:2];
            @(negedge clk);
            chk("ltssm", lto, lt);
            chk("rcb", rcbo, rows[i][1:0]);
            chk("obff", obo, ob);
        end
        $display("test rows done");
        rp = 0; dpa(2'h1, 5'h05, 2'h1); dpa(2'h1, 5'h05, 2'h0); dpa(2'h2, 5'h05, 2'h2);
        dpa(2'h3, 5'h09, 2'h3); rp = 1; dpa(2'h1, 5'h02, 2'h0);
        $display("test power allocation done");
        lev(3'h4, 3'h4, 1); lev(3'h2, 3'h2, 1); lev(3'h1, 3'h1, 1);
        lev(3'h1, 3'h6, 0); lev(3'h6, 3'h1, 0); rp = 0; lev(3'h1, 3'h7, 0);
        chk("user_events", cnt, 8'h06);
        $display("test link events done");
        ev = 3'h7; ie = 3'h0; clr = 3'h7;
        @(negedge clk); ev = 0; clr = 0;
        chk("set_wins", sts, 3'h7); chk("no_enable", nfy, 0);
        @(negedge clk); chk("sticky", sts, 3'h7); clr = 3'h7;
        @(negedge clk); clr = 0; chk("clear", sts, 0);
        $display("test set over clear done");
        rp = 1; ev = 3'h2; ie = 3'h2;
        @(negedge clk); ev = 0; rp = 0; rst = 1;
        @(negedge clk);
        chk("mid_ltssm", lto, 0); chk("mid_levels", {rcbo, obo}, 0);
        chk("mid_flags", {sts, nfy, dpo}, 0); chk("user_reset", cnt, 0);
        rst = 0;
        @(negedge clk); chk("ltssm_back", lto, lt); chk("rcb_back", rcbo, rcb);
        chk("obff_back", obo, ob);
        $display("test mid reset done");
        give_verdict();
    end
    initial
    begin
        #200000 errors++;
        give_verdict();
    end
endmodule
`default_nettype wire
